// >>> smc_top.sv
// shared serial module in two-wire slave role with apb register access
// assumes external pull-ups on both bus lines and a 20 MHz core_clk
// Summary of operation
// - writing data register mid-transfer sets collision flag; software clears it
// - data register write during a transfer is dropped
// - bus lines are only pulled low or released
// - two-wire role is slave only, transmit or receive
// - selected only when received address equals own seven-bit address
// - own address in bits 7..1, bit 0 reserved read/write, reset zero
// - own address register shares its location with four-wire control two
// - one eight-bit data register shared by both modes, reset undefined
// - clock line debounce of none, two or four system clocks
// - debounce counts internal system clocks
// - three-bit mode field selects clock source or slave role, resets 111
// - debounce field 00 none, 01 two, 1x four clocks
// - enable bit turns module on; off releases pins and idles logic
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module smc_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  logic [7:0] module_control_zero;
  logic [7:0] own_address_register;
  logic [7:0] shared_data_register;
  logic [7:0] timeout_control_register;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic write_collision_flag;
  logic addr_hit;
  logic xfer_done;
  logic rw_dir;
  logic rx_nack;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_filt;
  logic scl_prev;
  logic sda_prev;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic sda_drive_low;
  smc_pkg::smc_state_t state;
  smc_pkg::smc_state_t next_state;

  // bus decode
  wire apb_setup = psel && !penable;
  wire apb_acc = psel && penable;
  wire wr_en = apb_acc && pwrite;
  wire rd_en = apb_acc && !pwrite;
  wire hit_ctrl0 = paddr == smc_pkg::ADDR_CTRL0;
  wire hit_status = paddr == smc_pkg::ADDR_STATUS;
  wire hit_data = paddr == smc_pkg::ADDR_DATA;
  wire hit_own = paddr == smc_pkg::ADDR_OWN;
  wire hit_toc = paddr == smc_pkg::ADDR_TOC;
  wire hit_istat = paddr == smc_pkg::ADDR_IRQ_STAT;
  wire hit_imask = paddr == smc_pkg::ADDR_IRQ_MASK;
  wire mapped = hit_ctrl0 | hit_status | hit_data | hit_own | hit_toc | hit_istat | hit_imask;
  wire [2:0] op_mode = module_control_zero[smc_pkg::MODE_LSB +: 3];
  wire [1:0] deb_sel = module_control_zero[smc_pkg::DEB_LSB +: 2];
  wire module_on = module_control_zero[smc_pkg::EN_BIT];
  wire twi_on = module_on && (op_mode == smc_pkg::MODE_TWI_S);
  wire busy = twi_on && (state != smc_pkg::SMC_IDLE);
  wire data_wr = wr_en && hit_data;
  wire collide = data_wr && busy;

  // single-cycle access, unmapped addresses answer with an error
  assign pready = apb_acc;
  assign pslverr = apb_acc && !mapped;
  assign irq = |(irq_stat & irq_mask);

  // clock and data lines pass three flops; a change counts when the last two agree
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  logic scl_agree;
  logic sda_agree;
  // holds last agreed level so a disagreeing pair is not seen as a change
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      scl_agree <= 1'b1;
      sda_agree <= 1'b1;
    end
    else
    begin
      if (scl_sync[1] == scl_sync[2])
        scl_agree <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_agree <= sda_sync[2];
    end
  end

  smc_debounce u_deb (
    .core_clk(core_clk),
    .srst(srst),
    .raw_in(scl_agree),
    .deb_sel(deb_sel),
    .filt_out(scl_filt)
  );

  // edge and bus condition detection on the filtered lines
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_prev <= scl_filt;
      sda_prev <= sda_agree;
    end
  end
  wire scl_rise = scl_filt && !scl_prev;
  wire scl_fall = !scl_filt && scl_prev;
  wire start_cond = scl_filt && scl_prev && sda_prev && !sda_agree;
  wire stop_cond = scl_filt && scl_prev && !sda_prev && sda_agree;
  // byte taken at the eighth fall itself; the registered done pulse shows in the same cycle as the new state
  wire rx_store = scl_fall && state == smc_pkg::SMC_RECV && bit_cnt == 4'h8;
  wire own_match = shifter[7:1] == own_address_register[7:1];
  wire [7:0] rx_byte = {shifter[6:0], sda_agree};

  // slave sequencer; a stop or disable returns it to idle from anywhere
  always_comb
  begin
    next_state = state;
    unique case (state)
      smc_pkg::SMC_IDLE: if (start_cond) next_state = smc_pkg::SMC_ADDR;
      smc_pkg::SMC_ADDR: if (scl_fall && bit_cnt == 4'h8)
        next_state = own_match ? smc_pkg::SMC_ACK : smc_pkg::SMC_IDLE;
      smc_pkg::SMC_RECV: if (scl_fall && bit_cnt == 4'h8) next_state = smc_pkg::SMC_ACK;
      smc_pkg::SMC_SEND: if (scl_fall && bit_cnt == 4'h8) next_state = smc_pkg::SMC_ACK;
      smc_pkg::SMC_ACK: if (scl_fall)
        next_state = (rw_dir && rx_nack) ? smc_pkg::SMC_IDLE :
                     (rw_dir ? smc_pkg::SMC_SEND : smc_pkg::SMC_RECV);
    endcase
    if (!twi_on || stop_cond)
      next_state = smc_pkg::SMC_IDLE;
    else if (start_cond)
      next_state = smc_pkg::SMC_ADDR;
  end

  // shift engine: sample on rising clock, change drive on falling clock
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state <= smc_pkg::SMC_IDLE;
      bit_cnt <= 4'h0;
      shifter <= 8'h00;
      sda_drive_low <= 1'b0;
      rw_dir <= 1'b0;
      rx_nack <= 1'b0;
      addr_hit <= 1'b0;
      xfer_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      addr_hit <= 1'b0;
      xfer_done <= 1'b0;
      if (next_state != state)
        bit_cnt <= 4'h0;
      if (next_state == smc_pkg::SMC_IDLE)
        sda_drive_low <= 1'b0;
      else if (scl_rise && state != smc_pkg::SMC_ACK && state != smc_pkg::SMC_IDLE)
      begin
        shifter <= rx_byte;
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_rise && state == smc_pkg::SMC_ACK && rw_dir)
        rx_nack <= sda_agree;
      if (scl_fall && next_state == state && state == smc_pkg::SMC_SEND)
        sda_drive_low <= !shifter[7];
      if (scl_fall && state == smc_pkg::SMC_ADDR && bit_cnt == 4'h8 && own_match)
      begin
        rw_dir <= shifter[0];
        addr_hit <= 1'b1;
        sda_drive_low <= 1'b1; // acknowledge own address
      end
      if (scl_fall && state == smc_pkg::SMC_RECV && bit_cnt == 4'h8)
      begin
        xfer_done <= 1'b1;
        sda_drive_low <= 1'b1;
      end
      if (scl_fall && state == smc_pkg::SMC_SEND && bit_cnt == 4'h8)
      begin
        xfer_done <= 1'b1;
        sda_drive_low <= 1'b0; // release for master acknowledge
      end
      if (scl_fall && state == smc_pkg::SMC_ACK && next_state == smc_pkg::SMC_SEND)
      begin
        shifter <= shared_data_register; // each rise lifts the next bit to the top
        sda_drive_low <= !shared_data_register[7];
      end
      else if (scl_fall && state == smc_pkg::SMC_ACK)
        sda_drive_low <= 1'b0;
    end
  end

  // open-drain drive: output always low, enable only while pulling down
  assign sda_out = 1'b0;
  assign sda_oe = twi_on && sda_drive_low;
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0; // slave never stretches the clock

  // control, address and timeout registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      module_control_zero <= smc_pkg::CTRL0_RESET;
      own_address_register <= smc_pkg::OWN_RESET;
      timeout_control_register <= smc_pkg::TOC_RESET;
      irq_mask <= 4'h0;
    end
    else if (wr_en)
    begin
      if (hit_ctrl0)
        module_control_zero <= pwdata[7:0] & smc_pkg::CTRL0_WMASK;
      if (hit_own)
        own_address_register <= pwdata[7:0];
      if (hit_toc)
        timeout_control_register <= pwdata[7:0];
      if (hit_imask)
        irq_mask <= pwdata[3:0];
    end
  end

  // data register has no reset value; transfer and software share it
  always_ff @(posedge core_clk)
  begin
    if (data_wr && !busy)
      shared_data_register <= pwdata[7:0];
    else if (rx_store)
      shared_data_register <= shifter;
  end

  // collision flag: set wins over a software clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
      write_collision_flag <= 1'b0;
    else if (collide)
      write_collision_flag <= 1'b1;
    else if (wr_en && hit_status && !pwdata[smc_pkg::ST_WRITE_COLLISION_FLAG])
      write_collision_flag <= 1'b0;
  end

  wire read_istat = rd_en && hit_istat;
  wire [3:0] irq_set = {xfer_done && !rw_dir, collide, xfer_done, addr_hit};
  // sticky events cleared by reading; a new event in the read cycle survives
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq_stat <= 4'h0;
    else
      irq_stat <= (read_istat ? 4'h0 : irq_stat) | irq_set;
  end

  wire [7:0] status_view = {1'b0, state == smc_pkg::SMC_ADDR, busy, rw_dir && busy,
                            1'b0, rw_dir, write_collision_flag, rx_nack};
  wire [7:0] rd_mux = hit_ctrl0 ? module_control_zero :
                      hit_status ? status_view :
                      hit_data ? shared_data_register :
                      hit_own ? own_address_register :
                      hit_toc ? timeout_control_register :
                      hit_istat ? {4'h0, irq_stat} :
                      hit_imask ? {4'h0, irq_mask} : 8'h00;
  // read data registered in the setup phase so it stands through the access
  always_ff @(posedge core_clk)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (apb_setup)
      prdata <= {24'h00_0000, rd_mux};
  end
endmodule // smc_top

// >>> smc_pkg.sv
// package for the shared serial module: register map, field layout, reset values, modes
// assumes a 32-bit apb slave with word-aligned registers
package smc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_OWN = 8'h0C;
  localparam logic [7:0] ADDR_TOC = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // control zero layout
  localparam int MODE_LSB = 5;
  localparam int DEB_LSB = 2;
  localparam int EN_BIT = 1;
  localparam int ICF_BIT = 0;
  localparam logic [7:0] CTRL0_RESET = 8'hE0;
  localparam logic [7:0] CTRL0_WMASK = 8'hEF;
  localparam logic [7:0] OWN_RESET = 8'h00;
  localparam logic [7:0] TOC_RESET = 8'h00;
  // status layout (bus_status_register subset)
  localparam int ST_BUSY = 5;
  localparam int ST_TX = 4;
  localparam int ST_ADDR_HIT = 6;
  localparam int ST_COMPLETE = 7;
  localparam int ST_RW = 2;
  localparam int ST_RXAK = 0;
  localparam int ST_WRITE_COLLISION_FLAG = 1;
  // interrupt status bits
  localparam int IRQ_ADDR = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_WRITE_COLLISION_FLAG = 2;
  localparam int IRQ_W = 3;
  // operating modes
  localparam logic [2:0] MODE_M4 = 3'h0;
  localparam logic [2:0] MODE_M16 = 3'h1;
  localparam logic [2:0] MODE_M64 = 3'h2;
  localparam logic [2:0] MODE_MSUB = 3'h3;
  localparam logic [2:0] MODE_MTMR = 3'h4;
  localparam logic [2:0] MODE_SPI_S = 3'h5;
  localparam logic [2:0] MODE_TWI_S = 3'h6;
  localparam logic [2:0] MODE_NONE = 3'h7;
  // debounce lengths in system clocks
  localparam logic [2:0] DEB_OFF = 3'h1;
  localparam logic [2:0] DEB_TWO = 3'h2;
  localparam logic [2:0] DEB_FOUR = 3'h4;
  // two-wire slave sequencer states
  typedef enum logic [4:0] {
    SMC_IDLE = 5'h01,
    SMC_ADDR = 5'h02,
    SMC_RECV = 5'h04,
    SMC_SEND = 5'h08,
    SMC_ACK = 5'h10
  } smc_state_t;
endpackage

// >>> smc_debounce.sv
// glitch filter for the incoming bus clock line
// assumes the input is already synchronised to core_clk
`timescale 1ns/1ps
module smc_debounce (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic raw_in,
  input wire logic [1:0] deb_sel,
  output logic filt_out
);
  logic [2:0] stable_cnt;
  logic [2:0] need;
  // 00 none, 01 two clocks, 1x four clocks
  assign need = deb_sel[1] ? smc_pkg::DEB_FOUR :
                (deb_sel[0] ? smc_pkg::DEB_TWO : smc_pkg::DEB_OFF);
  // new level taken only after it stood for the selected run of clocks
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stable_cnt <= 3'h0;
      filt_out <= 1'b1;
    end
    else if (raw_in == filt_out)
      stable_cnt <= 3'h0;
    else if (stable_cnt + 3'h1 >= need)
    begin
      filt_out <= raw_in;
      stable_cnt <= 3'h0;
    end
    else
      stable_cnt <= stable_cnt + 3'h1;
  end
endmodule // smc_debounce

// >>> smc_chk.sv
// concurrent checks on the smc_top ports, with a mirror of software writes
// assumes it is bound to smc_top and sees only that module's ports
`timescale 1ns/1ps
module smc_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  logic [7:0] own_q;
  logic [7:0] ctl_q;
  wire acc = psel && penable;
  wire rd_acc = acc && !pwrite;
  wire ctl_en = ctl_q[smc_pkg::EN_BIT];
  wire irq_touch = acc &&
    (paddr == smc_pkg::ADDR_IRQ_STAT || paddr == smc_pkg::ADDR_IRQ_MASK);
  // only the seven word offsets of the map answer without error
  wire hit_map = paddr inside {smc_pkg::ADDR_CTRL0, smc_pkg::ADDR_STATUS, smc_pkg::ADDR_DATA,
    smc_pkg::ADDR_OWN, smc_pkg::ADDR_TOC, smc_pkg::ADDR_IRQ_STAT, smc_pkg::ADDR_IRQ_MASK};
  // mirror of stored writes; the unimplemented control bit is masked off
  always_ff @(posedge core_clk)
    if (srst)
    begin
      own_q <= smc_pkg::OWN_RESET;
      ctl_q <= smc_pkg::CTRL0_RESET;
    end
    else if (acc && pwrite && paddr == smc_pkg::ADDR_OWN)
      own_q <= pwdata[7:0];
    else if (acc && pwrite && paddr == smc_pkg::ADDR_CTRL0)
      ctl_q <= pwdata[7:0] & smc_pkg::CTRL0_WMASK;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_pins_low_only: assert property (!sda_out && !scl_out) else $error("pin driven high");
  a_no_clock_drive: assert property (!scl_oe) else $error("clock line pulled");
  a_ack_clk_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("pull in clock high");
  a_zero_wait: assert property (acc |-> pready && pslverr == !hit_map)
    else $error("apb answer wrong");
  a_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h0) else $error("upper bits");
  a_own_readback: assert property (rd_acc && paddr == smc_pkg::ADDR_OWN |-> prdata[7:0] == own_q)
    else $error("own address readback");
  a_ctrl_readback: assert property (rd_acc && paddr == smc_pkg::ADDR_CTRL0
    |-> prdata[7:1] == ctl_q[7:1]) else $error("control readback");
  a_irq_cause: assert property ($fell(irq) |-> $past(irq_touch)) else $error("irq drop");
  // one cycle of grace after disabling, then the data pin must be free
  a_off_quiet: assert property (!ctl_en && !$past(ctl_en)
    |-> !sda_oe) else $error("disabled module pulls data");
  cover property (acc && pslverr);
  cover property ($rose(sda_oe));
  cover property ($rose(irq));
endmodule // smc_chk
bind smc_top smc_chk smc_chk_inst (
  .core_clk(core_clk),
  .srst(srst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .scl_in(scl_in),
  .scl_out(scl_out),
  .scl_oe(scl_oe),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .irq(irq)
);

// >>> smc_i2c_master.sv
// two-wire bus master model pulling the clock and data lines open-drain
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ps
module smc_i2c_master #(
  parameter int Q = 50 // quarter bit in core clocks, about 100 kHz at 20 MHz
) (
  input wire logic core_clk,
  input wire logic sda_in,
  output logic scl_oe_m,
  output logic sda_oe_m
);
  // both lines released until the first frame
  initial
  begin
    scl_oe_m = 1'b0;
    sda_oe_m = 1'b0;
  end
  task automatic wt(int n);
    repeat (n) @(posedge core_clk);
  endtask
  // also serves as a repeated start from a low clock
  task automatic start();
    sda_oe_m <= 1'b0;
    wt(Q);
    scl_oe_m <= 1'b0;
    wt(Q);
    sda_oe_m <= 1'b1; // data falls while clock high
    wt(Q);
    scl_oe_m <= 1'b1;
    wt(Q);
  endtask
  task automatic stop();
    sda_oe_m <= 1'b1;
    wt(Q);
    scl_oe_m <= 1'b0;
    wt(Q);
    sda_oe_m <= 1'b0; // data rises while clock high
    wt(Q);
  endtask
  // nine bits msb first; a one releases data so the slave may answer
  task automatic xfer(logic [8:0] tx, int g, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_oe_m <= !tx[i]; // only ever pulls low
      wt(Q);
      scl_oe_m <= 1'b0;
      wt(Q);
      if (i == 8 && g > 0)
      begin
        scl_oe_m <= 1'b1; // short clock glitch for the filter
        wt(g);
        scl_oe_m <= 1'b0;
      end
      rx[i] = sda_in;
      wt(Q);
      scl_oe_m <= 1'b1;
      wt(Q);
    end
  endtask
endmodule // smc_i2c_master

// >>> serial_module_i2c_slave_config_test.sv
// bench: apb master, register model and two-wire master around smc_top
// assumes smc_pkg, the design, the master model and the checker compile first
`timescale 1ns/1ps
module serial_module_i2c_slave_config_test;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, scl_oe_m, sda_oe_m, perr;
  // pull-ups: a line is low while any party pulls it
  wire scl_in = !(scl_oe_m || (scl_oe && !scl_out));
  wire sda_in = !(sda_oe_m || (sda_oe && !sda_out));
  int errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'hC26DC3D9;
  logic [7:0] mdl [0:7];
  logic [7:0] rxq [$];
  logic [8:0] r9;
  always #25 core_clk = !core_clk;
  smc_top smc_top_inst (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  smc_i2c_master smc_i2c_master_inst (.core_clk(core_clk), .sda_in(sda_in),
    .scl_oe_m(scl_oe_m), .sda_oe_m(sda_oe_m));
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one apb transfer; the model mirrors control, own address, timeout and mask writes
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      final_report();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a == smc_pkg::ADDR_CTRL0)
      mdl[0] = d[7:0] & smc_pkg::CTRL0_WMASK;
    else if (wr && a inside {smc_pkg::ADDR_OWN, smc_pkg::ADDR_TOC, smc_pkg::ADDR_IRQ_MASK})
      mdl[a[4:2]] = d[7:0];
  endtask
  task automatic rchk(logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk("reg", rd, {24'h0, mdl[a[4:2]]});
  endtask
  // start, address byte, one data byte when acked, stop
  task automatic frame(logic [7:0] a, int g, logic [7:0] d, logic ack);
    smc_i2c_master_inst.start();
    smc_i2c_master_inst.xfer({a, 1'b1}, g, r9);
    chk("addr ack", 32'(!r9[0]), 32'(ack));
    if (ack)
    begin
      smc_i2c_master_inst.xfer({d, 1'b1}, 0, r9);
      chk("data ack", 32'(r9[0]), 32'h0);
      rxq.push_back(d);
    end
    smc_i2c_master_inst.stop();
  endtask
  initial
  begin
    mdl = '{default: 8'h00};
    mdl[0] = smc_pkg::CTRL0_RESET;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    // reset values, unmapped word, plain storage
    foreach (mdl[i])
      if (i inside {0, 3, 4, 6})
        rchk(8'(i * 4));
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", {rd[30:0], perr}, 32'h1);
    seed = lfsr(seed);
    apb(1'b1, smc_pkg::ADDR_TOC, seed);
    rchk(smc_pkg::ADDR_TOC);
    apb(1'b1, smc_pkg::ADDR_OWN, 32'hB5);
    rchk(smc_pkg::ADDR_OWN);
    apb(1'b1, smc_pkg::ADDR_IRQ_MASK, 32'hF);
    // each filter code meets a three-clock glitch on the first address bit
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, smc_pkg::ADDR_CTRL0, {24'h0, smc_pkg::MODE_TWI_S, 1'b0, 2'(i), 2'b10});
      rchk(smc_pkg::ADDR_CTRL0);
      seed = lfsr(seed);
      frame(8'hB4, 3, seed[7:0], i >= 2);
      chk("irq", 32'(irq), 32'(i >= 2));
      apb(1'b0, smc_pkg::ADDR_IRQ_STAT, 32'h0);
      chk("hit", rd & 32'h1, 32'(i >= 2));
      if (i >= 2)
      begin
        apb(1'b0, smc_pkg::ADDR_DATA, 32'h0);
        chk("rx", rd, {24'h0, rxq.pop_front()});
      end
    end
    // read transfer with a data write landing mid-byte; only collision unmasked
    apb(1'b1, smc_pkg::ADDR_IRQ_MASK, 32'h4);
    apb(1'b1, smc_pkg::ADDR_DATA, 32'hA5);
    smc_i2c_master_inst.start();
    smc_i2c_master_inst.xfer({8'hB5, 1'b1}, 0, r9);
    chk("rd ack", {r9[0], 31'(irq)}, 32'h0);
    fork
      smc_i2c_master_inst.xfer({8'hFF, 1'b1}, 0, r9);
      begin
        repeat (300) @(posedge core_clk);
        apb(1'b1, smc_pkg::ADDR_DATA, 32'h0);
      end
    join
    smc_i2c_master_inst.stop();
    chk("tx", {r9[8:1], 24'(irq)}, {8'hA5, 24'h1});
    apb(1'b0, smc_pkg::ADDR_STATUS, 32'h0);
    chk("write_collision_flag", rd & 32'h2, 32'h2);
    apb(1'b1, smc_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, smc_pkg::ADDR_STATUS, 32'h0);
    chk("write_collision_flag clr", rd & 32'h2, 32'h0);
    apb(1'b0, smc_pkg::ADDR_IRQ_STAT, 32'h0);
    @(negedge core_clk);
    chk("irq clr", {rd[2], 31'(irq)}, 32'h80000000);
    // a disabled module stays off the bus
    apb(1'b1, smc_pkg::ADDR_CTRL0, {24'h0, smc_pkg::MODE_TWI_S, 5'b01000});
    frame(8'hB4, 0, 8'h00, 1'b0);
    final_report();
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge core_clk);
    errors++;
    final_report();
  end
endmodule // serial_module_i2c_slave_config_test
